//--- hdl/fprc_top.sv
// Purpose: CPU reprogramming controller for on-chip flash
// Assumes: register port and flash port from the CPU, synchronous inputs
// Notes: the array is a small model; area = top two flash address bits
// Operation
// - mode needs select bit and high voltage
// - monitor flag shows mode in effect
// - busy flag high during program or erase
// - erase clears only selected area
// - programming allowed only in selected area
// - code 00 enters read mode
// - read mode holds until new command
// - code 40 then byte write programs
// - watchdog halted at FFFF while busy
// - code C0 enters program verify reads
// - code 20 twice erases selected area
// - code A0 enters erase verify reads
// - FF twice cancels pending program or erase
`timescale 1ns/100ps
module fprc_top
    import fprc_pkg::*;
#(
    parameter int AW = 6,
    parameter int PROG_CYCLES = PROG_CYC,
    parameter int ERASE_CYCLES = ERASE_CYC
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic [15:0] flashAddr,
    input wire logic [7:0] flashWdata,
    input wire logic flashWr,
    input wire logic flashRd,
    output logic [7:0] flashRdata,
    input wire logic highProgVoltage,
    output logic wdtHalt,
    output logic [15:0] wdtLoad,
    output logic irq
);
    localparam int CW = 24;
    typedef struct packed {
        logic [7:0] ctrl;
        fprc_mode_t mode;
        fprc_mode_t pend;
        logic isErase;
        logic [7:0] stat;
        logic [7:0] mask;
        logic [7:0] rdata;
        logic [7:0] frdata;
        logic halt;
        logic [15:0] wload;
        logic irq;
        logic [AW-1:0] opAddr;
        logic [7:0] opData;
    } fprc_st_t;
    fprc_st_t st_reg, st_next;
    logic tStart, tRun, tDone, progEn, eraseEn, inMode;
    logic [CW-1:0] tLoad;
    logic [7:0] arrData;
    logic [AW-1:0] arrAddr;
    logic [1:0] area;
    logic cmdWr;
    assign area = st_reg.ctrl[AREA_LO+1:AREA_LO];
    assign inMode = st_reg.ctrl[SEL_BIT] & highProgVoltage;
    assign cmdWr = regWr && regAddr == CMD_ADDR && inMode;
    assign arrAddr = (st_reg.mode == MD_BUSY) ? st_reg.opAddr : flashAddr[AW-1:0];
    always_comb
    begin
        st_next = st_reg;
        tStart = 1'b0;
        tLoad = '0;
        progEn = 1'b0;
        eraseEn = 1'b0;
        // clear on read first so that an event of the same cycle is kept
        if (regRd && regAddr == STAT_ADDR)
            st_next.stat = 8'h00;
        // register writes
        if (regWr)
        begin
            if (regAddr == CTRL_ADDR)
                st_next.ctrl = (regWdata & CTRL_WMASK) | (st_reg.ctrl & ~CTRL_WMASK);
            else if (regAddr == MASK_ADDR)
                st_next.mask = regWdata;
        end
        // command interpreter
        if (!inMode)
            st_next.mode = (st_reg.mode == MD_BUSY) ? MD_BUSY : MD_READ;
        else if (cmdWr && st_reg.mode != MD_BUSY)
        begin
            if (regWdata == CMD_RESET && (st_reg.mode == MD_PROG
                || st_reg.mode == MD_ERASE1))
                st_next.mode = MD_RESET1;
            else if (regWdata == CMD_RESET && st_reg.mode == MD_RESET1)
                st_next.mode = MD_READ;
            else if (regWdata == CMD_ERASE && st_reg.mode == MD_ERASE1)
            begin
                st_next.mode = MD_BUSY;
                st_next.isErase = 1'b1;
                tStart = 1'b1;
                // the start cycle counts as the first busy cycle
                tLoad = CW'(ERASE_CYCLES - 1);
            end
            else if (regWdata == CMD_ERASE)
                st_next.mode = MD_ERASE1;
            else if (regWdata == CMD_PROG)
                st_next.mode = MD_PROG;
            else if (regWdata == CMD_PVFY)
                st_next.mode = MD_PVFY;
            else if (regWdata == CMD_EVFY)
                st_next.mode = MD_EVFY;
            else
                st_next.mode = MD_READ;
        end
        // byte write to flash
        if (flashWr && inMode && st_reg.mode == MD_PROG)
        begin
            if (fprc_area(flashAddr) == area)
            begin
                st_next.mode = MD_BUSY;
                st_next.isErase = 1'b0;
                st_next.opAddr = flashAddr[AW-1:0];
                st_next.opData = flashWdata;
                tStart = 1'b1;
                tLoad = CW'(PROG_CYCLES - 1);
            end
            else
                st_next.stat[EV_REJECT] = 1'b1;
        end
        // writes in other modes fall through unused
        // operation end
        if (tDone)
        begin
            if (st_reg.isErase)
            begin
                eraseEn = 1'b1;
                st_next.stat[EV_ERASE] = 1'b1;
                st_next.mode = MD_EVFY;
            end
            else
            begin
                progEn = 1'b1;
                st_next.stat[EV_PROG] = 1'b1;
                st_next.mode = MD_PVFY;
            end
        end
        st_next.ctrl[BUSY_BIT] = tStart | (tRun & !tDone);
        st_next.ctrl[MON_BIT] = inMode;
        st_next.halt = tStart | (tRun & !tDone);
        st_next.wload = WDT_LOAD;
        // flash read: all modes return cell contents, the busy mode at the operation address
        st_next.frdata = flashRd ? arrData : 8'h00;
        // register reads; status clears on read, set wins
        st_next.rdata = 8'h00;
        if (regRd)
        begin
            if (regAddr == CTRL_ADDR)
                st_next.rdata = st_reg.ctrl;
            else if (regAddr == STAT_ADDR)
            begin
                st_next.rdata = st_reg.stat;
            end
            else if (regAddr == MASK_ADDR)
                st_next.rdata = st_reg.mask;
        end
        st_next.irq = |(st_next.stat & st_next.mask);
    end
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            st_reg <= '0;
            st_reg.mode <= MD_READ;
            st_reg.pend <= MD_READ;
            st_reg.wload <= WDT_LOAD;
        end
        else
            st_reg <= st_next;
    end
    fprc_timer #(.CW(CW)) u_timer (
        .clk(clk),
        .nrst(nrst),
        .start(tStart),
        .load(tLoad),
        .running(tRun),
        .done(tDone)
    );
    fprc_flash_array #(.AW(AW)) u_array (
        .clk(clk),
        .nrst(nrst),
        .addr(arrAddr),
        .rdata(arrData),
        .progEn(progEn),
        .progData(st_reg.opData),
        .eraseEn(eraseEn),
        .eraseArea(area)
    );
    assign regRdata = st_reg.rdata;
    assign flashRdata = st_reg.frdata;
    assign wdtHalt = st_reg.halt;
    assign wdtLoad = st_reg.wload;
    assign irq = st_reg.irq;
    // assertions
    mode_needs_volt_a: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.ctrl[MON_BIT] |-> $past(st_reg.ctrl[SEL_BIT] & highProgVoltage))
        else $error("monitor set without select and voltage");
    monitor_track_a: assert property (@(posedge clk) disable iff (!nrst)
        ##1 st_reg.ctrl[MON_BIT] == $past(inMode))
        else $error("monitor flag wrong");
    busy_prog_a: assert property (@(posedge clk) disable iff (!nrst)
        (flashWr && inMode && st_reg.mode == MD_PROG && fprc_area(flashAddr) == area)
        |=> st_reg.ctrl[BUSY_BIT] ##1 st_reg.ctrl[BUSY_BIT])
        else $error("busy not raised for program");
    wdt_frozen_a: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.ctrl[BUSY_BIT] |-> wdtHalt && wdtLoad == WDT_LOAD)
        else $error("watchdog not frozen");
    wrong_area_a: assert property (@(posedge clk) disable iff (!nrst)
        (flashWr && st_reg.mode == MD_PROG && fprc_area(flashAddr) != area)
        |=> !(st_reg.mode == MD_BUSY && !st_reg.isErase && $rose(st_reg.ctrl[BUSY_BIT])))
        else $error("program outside selected area");
    read_cmd_a: assert property (@(posedge clk) disable iff (!nrst)
        (cmdWr && st_reg.mode != MD_BUSY && regWdata == CMD_READ) |=> st_reg.mode == MD_READ)
        else $error("read command ignored");
    erase_two_a: assert property (@(posedge clk) disable iff (!nrst)
        (cmdWr && st_reg.mode == MD_ERASE1 && regWdata == CMD_ERASE)
        |=> st_reg.mode == MD_BUSY && st_reg.isErase)
        else $error("double erase code did not start");
    reset_cancel_a: assert property (@(posedge clk) disable iff (!nrst)
        (cmdWr && st_reg.mode == MD_RESET1 && regWdata == CMD_RESET)
        |=> st_reg.mode == MD_READ && !st_reg.ctrl[BUSY_BIT])
        else $error("reset command did not return to read");
    write_ignored_a: assert property (@(posedge clk) disable iff (!nrst)
        (flashWr && st_reg.mode != MD_PROG && st_reg.mode != MD_BUSY)
        |=> !$rose(st_reg.ctrl[BUSY_BIT]))
        else $error("write outside program mode started op");
    prog_cov_c: cover property (@(posedge clk) $fell(st_reg.ctrl[BUSY_BIT]) && !st_reg.isErase);
    erase_cov_c: cover property (@(posedge clk) $fell(st_reg.ctrl[BUSY_BIT]) && st_reg.isErase);
    cancel_cov_c: cover property (@(posedge clk) st_reg.mode == MD_RESET1);
    irq_cov_c: cover property (@(posedge clk) $rose(irq));
endmodule

//--- hdl/fprc_pkg.sv
// Purpose: shared constants for the flash reprogramming controller
// Assumes: byte-wide register port, 125 MHz clock
// Notes: register offsets and command codes live here
package fprc_pkg;
    // register map (word index = byte address / 4)
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] CMD_ADDR = 8'h04;
    localparam logic [7:0] STAT_ADDR = 8'h08;
    localparam logic [7:0] MASK_ADDR = 8'h0C;
    // control register fields
    localparam int SEL_BIT = 0;
    localparam int BUSY_BIT = 1;
    localparam int MON_BIT = 2;
    localparam int AREA_LO = 4;
    localparam logic [7:0] CTRL_WMASK = 8'h31;
    // command codes
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_PROG = 8'h40;
    localparam logic [7:0] CMD_PVFY = 8'hC0;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_EVFY = 8'hA0;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [15:0] WDT_LOAD = 16'hFFFF;
    // operation times and derived cycle counts at 125 MHz
    localparam int CLK_MHZ = 125;
    localparam int PROG_TIME_US = 10;
    localparam int ERASE_TIME_US = 9500;
    localparam int PROG_CYC = PROG_TIME_US * CLK_MHZ;
    localparam int ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
    // interrupt status bits
    localparam int EV_PROG = 0;
    localparam int EV_ERASE = 1;
    localparam int EV_REJECT = 2;
    typedef enum logic [2:0] {
        MD_READ = 3'b000,
        MD_PROG = 3'b001,
        MD_PVFY = 3'b010,
        MD_ERASE1 = 3'b011,
        MD_EVFY = 3'b100,
        MD_RESET1 = 3'b101,
        MD_BUSY = 3'b110
    } fprc_mode_t;
    // area of a flash address: top two address bits
    function automatic logic [1:0] fprc_area(input logic [15:0] a);
        return a[15:14];
    endfunction
endpackage

//--- hdl/fprc_timer.sv
// Purpose: countdown timer for program and erase operations
// Assumes: start is a one-cycle pulse
// Notes: done pulses one cycle when the count runs out
`timescale 1ns/100ps
module fprc_timer
    import fprc_pkg::*;
#(
    parameter int CW = 24
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [CW-1:0] load,
    output logic running,
    output logic done
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic run;
        logic fin;
    } fprc_tmr_t;
    fprc_tmr_t st_reg, st_next;
    always_comb
    begin
        st_next = st_reg;
        st_next.fin = 1'b0;
        if (start)
        begin
            st_next.cnt = load;
            st_next.run = 1'b1;
        end
        else if (st_reg.run)
        begin
            if (st_reg.cnt <= CW'(1))
            begin
                st_next.run = 1'b0;
                st_next.fin = 1'b1;
                st_next.cnt = '0;
            end
            else
                st_next.cnt = st_reg.cnt - CW'(1);
        end
    end
    always_ff @(posedge clk)
    begin
        if (!nrst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
    assign running = st_reg.run;
    assign done = st_reg.fin;
    run_ends_a: assert property (@(posedge clk) disable iff (!nrst)
        st_reg.fin |-> !st_reg.run) else $error("timer done while running");
endmodule

//--- hdl/fprc_flash_array.sv
// Purpose: flip-flop model of the flash cell array, erased per area
// Assumes: one program or erase request at a time
// Notes: programming only clears bits, like real cells
`timescale 1ns/100ps
module fprc_flash_array
    import fprc_pkg::*;
#(
    parameter int AW = 6
)(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [AW-1:0] addr,
    output logic [7:0] rdata,
    input wire logic progEn,
    input wire logic [7:0] progData,
    input wire logic eraseEn,
    input wire logic [1:0] eraseArea
);
    typedef struct packed {
        logic [(1<<AW)-1:0][7:0] mem;
    } fprc_arr_t;
    fprc_arr_t st_reg, st_next;
    always_comb
    begin
        st_next = st_reg;
        if (progEn)
            st_next.mem[addr] = st_reg.mem[addr] & progData;
        if (eraseEn)
            for (int i = 0; i < (1 << AW); i++)
                if (2'(i >> (AW - 2)) == eraseArea)
                    st_next.mem[i] = ERASED_BYTE;
    end
    always_ff @(posedge clk)
    begin
        if (!nrst)
            st_reg <= '1;
        else
            st_reg <= st_next;
    end
    assign rdata = st_reg.mem[addr];
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench for the flash reprogramming controller
// Assumes: shortened operation times of 20 and 50 cycles
// Notes: register cases come from a table; operations are written out by hand
`timescale 1ns/100ps
module tb
    import fprc_pkg::*;
;
    localparam int PC = 20;
    localparam int EC = 50;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic volt;
        logic [7:0] exp;
    } fprc_row_t;
    // monitor must follow select and voltage together; command reads 0
    fprc_row_t rows [6] = '{
        '{CTRL_ADDR, 8'hFF, 1'h0, 8'h31},
        '{CTRL_ADDR, 8'h01, 1'h1, 8'h05},
        '{CTRL_ADDR, 8'h30, 1'h1, 8'h30},
        '{CMD_ADDR, 8'h40, 1'h0, 8'h00},
        '{MASK_ADDR, 8'h07, 1'h0, 8'h07},
        '{8'h10, 8'hAA, 1'h0, 8'h00}
    };
    logic clk, nrst, regWr, regRd, flashWr, flashRd, highProgVoltage, wdtHalt, irq;
    logic [7:0] regAddr, regWdata, regRdata, flashWdata, flashRdata;
    logic [15:0] flashAddr, wdtLoad;
    int fails, compares, cyc, haltCnt;
    fprc_top #(.AW(6), .PROG_CYCLES(PC), .ERASE_CYCLES(EC)) dut (
        .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .flashAddr(flashAddr), .flashWdata(flashWdata),
        .flashWr(flashWr), .flashRd(flashRd), .flashRdata(flashRdata),
        .highProgVoltage(highProgVoltage), .wdtHalt(wdtHalt), .wdtLoad(wdtLoad), .irq(irq)
    );
    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    // halt cycles are counted here so the tests need not poll in lockstep
    always @(posedge clk)
    begin
        cyc++;
        if (wdtHalt === 1'h1)
            haltCnt++;
        if (cyc == 3000)
        begin
            fails++;
            $display("timeout after %0d cycles", cyc);
            end_sim();
        end
    end
    task automatic end_sim();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // every task starts and ends just after a rising edge; a gap cycle between strobes
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'h1;
        @(posedge clk);
        regWr <= 1'h0;
        @(posedge clk);
    endtask
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge clk);
        regRd <= 1'h0;
        #1 check(name, {8'h00, regRdata}, {8'h00, exp});
        @(posedge clk);
    endtask
    task automatic fl_wr(input logic [15:0] a, input logic [7:0] d);
        flashAddr <= a;
        flashWdata <= d;
        flashWr <= 1'h1;
        @(posedge clk);
        flashWr <= 1'h0;
        @(posedge clk);
    endtask
    task automatic fl_chk(input logic [15:0] a, input logic [7:0] exp, input string name);
        flashAddr <= a;
        flashRd <= 1'h1;
        @(posedge clk);
        flashRd <= 1'h0;
        #1 check(name, {8'h00, flashRdata}, {8'h00, exp});
        @(posedge clk);
    endtask
    // follows a launched program or erase: busy, watchdog freeze, event and interrupt
    task automatic op_chk(input int n, input logic [7:0] ctrl, input logic [7:0] st);
        int k;
        reg_chk(CTRL_ADDR, ctrl | 8'h02, "busy set");
        k = 0;
        while (wdtHalt !== 1'h0 && k < 500)
        begin
            @(posedge clk);
            k++;
        end
        @(posedge clk);
        check("halt cycles", 16'(haltCnt), 16'(n));
        check("watchdog load", wdtLoad, WDT_LOAD);
        reg_chk(CTRL_ADDR, ctrl, "busy cleared");
        check("irq raised", {15'h0000, irq}, 16'h0001);
        reg_chk(STAT_ADDR, st, "status");
        #1 check("irq cleared", {15'h0000, irq}, 16'h0000);
        @(posedge clk);
    endtask
    initial
    begin
        fails = 0;
        compares = 0;
        cyc = 0;
        haltCnt = 0;
        nrst = 1'h0;
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWr = 1'h0;
        regRd = 1'h0;
        flashAddr = 16'h0000;
        flashWdata = 8'h00;
        flashWr = 1'h0;
        flashRd = 1'h0;
        highProgVoltage = 1'h0;
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        check("watchdog load", wdtLoad, WDT_LOAD);
        reg_chk(CTRL_ADDR, 8'h00, "ctrl reset");
        fl_chk(16'h4012, ERASED_BYTE, "read after reset");
        foreach (rows[i])
        begin
            highProgVoltage <= rows[i].volt;
            reg_wr(rows[i].addr, rows[i].wdata);
            reg_chk(rows[i].addr, rows[i].exp, "register row");
        end
        $display("register table done");
        // select without voltage: commands and flash writes must do nothing
        reg_wr(CTRL_ADDR, 8'h11);
        reg_wr(CMD_ADDR, CMD_PROG);
        fl_wr(16'h4012, 8'h00);
        reg_chk(CTRL_ADDR, 8'h11, "no mode no busy");
        fl_chk(16'h4012, ERASED_BYTE, "no mode no program");
        highProgVoltage <= 1'h1;
        @(posedge clk);
        reg_chk(CTRL_ADDR, 8'h15, "monitor on");
        reg_wr(CMD_ADDR, CMD_PROG);
        haltCnt = 0;
        fl_wr(16'h4012, 8'h5A);
        op_chk(PC, 8'h15, 8'h01);
        reg_wr(CMD_ADDR, CMD_PVFY);
        fl_chk(16'h4012, 8'h5A, "program verify");
        fl_chk(16'h4013, ERASED_BYTE, "neighbour untouched");
        $display("program test done");
        // outside the selected area, with the event masked
        reg_wr(MASK_ADDR, 8'h00);
        reg_wr(CMD_ADDR, CMD_PROG);
        fl_wr(16'h8023, 8'h3C);
        reg_chk(CTRL_ADDR, 8'h15, "area refused");
        check("irq masked", {15'h0000, irq}, 16'h0000);
        reg_chk(STAT_ADDR, 8'h04, "reject status");
        reg_wr(MASK_ADDR, 8'h07);
        reg_wr(CMD_ADDR, CMD_RESET);
        reg_wr(CMD_ADDR, CMD_RESET);
        fl_wr(16'h4013, 8'h00);
        fl_chk(16'h4013, ERASED_BYTE, "write ignored");
        fl_chk(16'h8023, ERASED_BYTE, "other area kept");
        fl_chk(16'h4012, 8'h5A, "read mode a");
        fl_chk(16'h4012, 8'h5A, "read mode b");
        $display("area test done");
        reg_wr(CTRL_ADDR, 8'h21);
        reg_wr(CMD_ADDR, CMD_PROG);
        haltCnt = 0;
        fl_wr(16'h8023, 8'h3C);
        op_chk(PC, 8'h25, 8'h01);
        reg_wr(CTRL_ADDR, 8'h11);
        reg_wr(CMD_ADDR, CMD_ERASE);
        haltCnt = 0;
        reg_wr(CMD_ADDR, CMD_ERASE);
        op_chk(EC, 8'h15, 8'h02);
        reg_wr(CMD_ADDR, CMD_EVFY);
        fl_chk(16'h4012, ERASED_BYTE, "erase verify");
        fl_chk(16'h8023, 8'h3C, "erase spares area");
        $display("erase test done");
        // cancel both pending kinds; contents must survive
        reg_wr(CTRL_ADDR, 8'h21);
        reg_wr(CMD_ADDR, CMD_ERASE);
        reg_wr(CMD_ADDR, CMD_RESET);
        reg_wr(CMD_ADDR, CMD_RESET);
        check("no erase halt", {15'h0000, wdtHalt}, 16'h0000);
        fl_chk(16'h8023, 8'h3C, "erase cancelled");
        reg_wr(CMD_ADDR, CMD_PROG);
        reg_wr(CMD_ADDR, CMD_RESET);
        reg_wr(CMD_ADDR, CMD_RESET);
        fl_wr(16'h8024, 8'h00);
        fl_chk(16'h8024, ERASED_BYTE, "program cancelled");
        highProgVoltage <= 1'h0;
        @(posedge clk);
        reg_wr(CTRL_ADDR, 8'h00);
        reg_chk(CTRL_ADDR, 8'h00, "mode left");
        $display("cancel test done");
        nrst <= 1'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        fl_chk(16'h8023, ERASED_BYTE, "read after second reset");
        $display("reset test done");
        end_sim();
    end
endmodule
